// file: sccl_core.v
`timescale 1ns/1ps
`default_nettype none

`include "sccl_regs.vh"

module sccl_core #(
    parameter [`SCCL_CNT_W-1:0] TEMP_NORMAL_CYC =
        (`SCCL_TEMP_NORMAL_US * 1000000) / `SCCL_CLK_PERIOD_PS,
    parameter [`SCCL_CNT_W-1:0] TEMP_LOWPWR_CYC =
        (`SCCL_TEMP_LOWPWR_US * 1000000) / `SCCL_CLK_PERIOD_PS
) (
    input  wire                      mclk,
    input  wire                      sys_rst,
    input  wire                      secondary_pll_select_strap,
    input  wire [`SCCL_FREQ_W-1:0]   primary_ref_freq_strap,
    input  wire [`SCCL_FREQ_W-1:0]   secondary_ref_freq_strap,
    input  wire                      secondary_pll_enable,
    input  wire                      core_clock_source_select,
    input  wire                      core_clock_halve,
    input  wire [`SCCL_DIV_W-1:0]    core_clock_divider,
    input  wire                      primary_pll_lock,
    input  wire                      secondary_pll_lock,
    input  wire                      dpll_sync_active,
    input  wire                      temp_sensor_enable,
    output reg                       secondary_pll_on_q,
    output reg                       cpu_clock_source_q,
    output reg                       core_clock_source_q,
    output reg                       serdes_ref_source_q,
    output reg                       low_power_q,
    output wire                      core_clock_enable,
    output reg                       ts_clock_enable_q,
    output reg  [`SCCL_TS_STEP_W-1:0] ts_step_q,
    output reg                       temp_refresh_q,
    output reg  [`SCCL_IFG_W-1:0]    hdx_ifg_min_q,
    output reg  [`SCCL_IFG_W-1:0]    hdx_ifg_max_q,
    output reg                       primary_ref_ok_q,
    output reg                       secondary_ref_ok_q,
    output reg                       dpll_sync_allowed_q,
    output reg                       switching_q
);

    // ==========================================================
    // Strap capture
    reg                    rst_d1_q;
    reg                    strap_sec_q;
    reg [`SCCL_FREQ_W-1:0] strap_pfreq_q;
    reg [`SCCL_FREQ_W-1:0] strap_sfreq_q;

    // Caught on the first edge after release, not under reset
    always @(posedge mclk) begin
        rst_d1_q <= sys_rst;
        if (rst_d1_q && !sys_rst) begin
            strap_sec_q   <= secondary_pll_select_strap;
            strap_pfreq_q <= primary_ref_freq_strap;
            strap_sfreq_q <= secondary_ref_freq_strap;
        end
    end

    wire strap_valid = rst_d1_q && !sys_rst;
    wire sec_strap_now = strap_valid ? secondary_pll_select_strap : strap_sec_q;

    // ==========================================================
    // PLL lock synchronisers
    wire p_lock_s;
    wire s_lock_s;

    sccl_sync_edge u_sync_p (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (primary_pll_lock),
        .sync_out (p_lock_s)
    );

    sccl_sync_edge u_sync_s (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (secondary_pll_lock),
        .sync_out (s_lock_s)
    );

    // ==========================================================
    // PLL enables and source selection
    reg  cpu_set_q;
    wire sec_ok = secondary_pll_on_q && s_lock_s;
    wire req_src = (core_clock_source_select == `SCCL_SRC_SECONDARY)
                   ? `SCCL_SRC_SECONDARY : `SCCL_SRC_PRIMARY;
    wire div_tick;

    always @(posedge mclk) begin
        if (sys_rst) begin
            secondary_pll_on_q  <= 1'b0;
            cpu_clock_source_q  <= `SCCL_SRC_PRIMARY;
            cpu_set_q           <= 1'b0;
            core_clock_source_q <= `SCCL_SRC_PRIMARY;
            serdes_ref_source_q <= `SCCL_SRC_PRIMARY;
            switching_q         <= 1'b0;
        end else begin
            serdes_ref_source_q <= `SCCL_SRC_PRIMARY;
            if (sec_strap_now || secondary_pll_enable) begin
                secondary_pll_on_q <= 1'b1;
            end
            if (!cpu_set_q && strap_valid) begin
                cpu_set_q          <= 1'b1;
                cpu_clock_source_q <= secondary_pll_select_strap;
            end
            if (strap_valid) begin
                core_clock_source_q <= secondary_pll_select_strap;
            end else if (req_src != core_clock_source_q) begin
                // Wait for lock and a divider boundary so no runt pulse appears
                switching_q <= 1'b1;
                if (div_tick && (req_src == `SCCL_SRC_PRIMARY ? p_lock_s : sec_ok)) begin
                    core_clock_source_q <= req_src;
                    switching_q         <= 1'b0;
                end
            end else begin
                switching_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Low power mode: divider code 2 plus halving gives one third
    wire lp_req = core_clock_halve &&
                  (core_clock_divider == `SCCL_DIV_LOW_POWER);

    always @(posedge mclk) begin
        if (sys_rst) begin
            low_power_q <= 1'b0;
        end else if (div_tick) begin
            low_power_q <= lp_req;
        end
    end

    sccl_gate_div u_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ratio   (low_power_q ? `SCCL_LOW_POWER_RATIO - 2'h1 : `SCCL_DIV_NORMAL),
        .tick_q  (div_tick)
    );

    // Enable is glitch free: it is a registered pulse, never a gated clock
    assign core_clock_enable = div_tick;

    // ==========================================================
    // Timestamp resolution follows the core clock
    always @(posedge mclk) begin
        if (sys_rst) begin
            ts_clock_enable_q <= 1'b0;
            ts_step_q         <= `SCCL_TS_STEP_NORMAL;
        end else begin
            ts_clock_enable_q <= div_tick;
            ts_step_q <= low_power_q ? `SCCL_TS_STEP_LOWPWR : `SCCL_TS_STEP_NORMAL;
        end
    end

    // ==========================================================
    // Temperature sample refresh timer
    reg [`SCCL_CNT_W-1:0] temp_cnt_q;
    wire [`SCCL_CNT_W-1:0] temp_lim = low_power_q ? TEMP_LOWPWR_CYC : TEMP_NORMAL_CYC;

    always @(posedge mclk) begin
        if (sys_rst || !temp_sensor_enable) begin
            temp_cnt_q     <= {`SCCL_CNT_W{1'b0}};
            temp_refresh_q <= 1'b0;
        end else if (temp_cnt_q >= temp_lim - 1'b1) begin
            temp_cnt_q     <= {`SCCL_CNT_W{1'b0}};
            temp_refresh_q <= 1'b1;
        end else begin
            temp_cnt_q     <= temp_cnt_q + 1'b1;
            temp_refresh_q <= 1'b0;
        end
    end

    // ==========================================================
    // Half-duplex gap, reference checks, DPLL coexistence
    always @(posedge mclk) begin
        if (sys_rst) begin
            hdx_ifg_min_q       <= `SCCL_IFG_MIN_NORMAL;
            hdx_ifg_max_q       <= `SCCL_IFG_MIN_NORMAL;
            primary_ref_ok_q    <= 1'b0;
            secondary_ref_ok_q  <= 1'b0;
            dpll_sync_allowed_q <= 1'b0;
        end else begin
            hdx_ifg_min_q <= low_power_q ? `SCCL_IFG_MIN_LOWPWR : `SCCL_IFG_MIN_NORMAL;
            hdx_ifg_max_q <= low_power_q ? `SCCL_IFG_MAX_LOWPWR : `SCCL_IFG_MIN_NORMAL;
            primary_ref_ok_q <= (strap_pfreq_q <= `SCCL_FREQ_250);
            secondary_ref_ok_q <= (strap_sfreq_q == `SCCL_FREQ_125) ||
                                  (strap_sfreq_q == `SCCL_FREQ_156) ||
                                  (strap_sfreq_q == `SCCL_FREQ_250);
            // Low power never blocks the digital PLL path
            dpll_sync_allowed_q <= dpll_sync_active;
        end
    end

endmodule

`default_nettype wire

// file: sccl_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sccl_regs.vh"

// ==========================================================
// Port-level checker for the core clock control
module sccl_core_sva (
    input wire logic                      mclk,
    input wire logic                      sys_rst,
    input wire logic                      secondary_pll_enable,
    input wire logic                      core_clock_source_select,
    input wire logic                      secondary_pll_lock,
    input wire logic                      secondary_pll_on_q,
    input wire logic                      cpu_clock_source_q,
    input wire logic                      core_clock_source_q,
    input wire logic                      serdes_ref_source_q,
    input wire logic                      low_power_q,
    input wire logic                      core_clock_enable,
    input wire logic [`SCCL_TS_STEP_W-1:0] ts_step_q,
    input wire logic [`SCCL_IFG_W-1:0]    hdx_ifg_min_q,
    input wire logic [`SCCL_IFG_W-1:0]    hdx_ifg_max_q,
    input wire logic                      switching_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Sequences
    sequence s_lp_hold;
        low_power_q ##1 low_power_q;
    endsequence
    // A tick only counts once low power held at the previous load, else the first
    // period after entry is still a normal one
    sequence s_lp_tick;
        low_power_q ##1 core_clock_enable && low_power_q && !switching_q
        ##1 low_power_q && !switching_q;
    endsequence

    // ==========================================================
    // Assertions
    a_serdes_primary_only: assert property (serdes_ref_source_q == 1'b0)
        else $error("serializer reference left the primary pll");
    a_ifg_low_power: assert property (s_lp_hold |-> hdx_ifg_min_q == 4'he && hdx_ifg_max_q == 4'hf)
        else $error("half duplex gap wrong in low power");
    a_ts_step_low: assert property (s_lp_hold |-> ts_step_q == 8'h0c)
        else $error("timestamp step wrong in low power");
    a_third_rate: assert property (s_lp_tick |-> !core_clock_enable ##1 !core_clock_enable ##1 core_clock_enable)
        else $error("core enable not one in three");
    a_normal_rate: assert property ((!low_power_q && !switching_q)[*3] |-> core_clock_enable)
        else $error("core enable missing in normal mode");
    a_cpu_src_fixed: assert property (!$past(sys_rst, 2) && !$past(sys_rst) |-> $stable(cpu_clock_source_q))
        else $error("cpu clock source moved after reset");
    a_enable_sticky_on: assert property (secondary_pll_enable |-> ##[1:3] secondary_pll_on_q)
        else $error("secondary pll not enabled by control");
    a_src_follow: assert property ((core_clock_source_select && secondary_pll_on_q && secondary_pll_lock && !low_power_q)[*6] |-> core_clock_source_q)
        else $error("core source did not follow select");
endmodule

bind sccl_core sccl_core_sva u_sva (.mclk(mclk), .sys_rst(sys_rst),
    .secondary_pll_enable(secondary_pll_enable), .core_clock_source_select(core_clock_source_select),
    .secondary_pll_lock(secondary_pll_lock), .secondary_pll_on_q(secondary_pll_on_q),
    .cpu_clock_source_q(cpu_clock_source_q), .core_clock_source_q(core_clock_source_q),
    .serdes_ref_source_q(serdes_ref_source_q), .low_power_q(low_power_q),
    .core_clock_enable(core_clock_enable), .ts_step_q(ts_step_q), .hdx_ifg_min_q(hdx_ifg_min_q),
    .hdx_ifg_max_q(hdx_ifg_max_q), .switching_q(switching_q));
`default_nettype wire

// file: sccl_gate_div.v
`timescale 1ns/1ps
`default_nettype none

`include "sccl_regs.vh"

// ==========================================================
// Clock enable pulse generator: one pulse every ratio plus one cycles
module sccl_gate_div (
    input  wire                    mclk,
    input  wire                    sys_rst,
    input  wire [`SCCL_DIV_W-1:0]  ratio,
    output reg                     tick_q
);
    reg [`SCCL_DIV_W-1:0] cnt_q;

    // Reload only at the wrap so a ratio change never shortens a period
    always @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q  <= {`SCCL_DIV_W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q == {`SCCL_DIV_W{1'b0}}) begin
            cnt_q  <= ratio;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - 1'b1;
            tick_q <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: sccl_regs.vh
`ifndef SCCL_REGS_VH
`define SCCL_REGS_VH

// ==========================================================
// Strap and clock-select encodings
`define SCCL_SRC_PRIMARY      1'b0
`define SCCL_SRC_SECONDARY    1'b1
`define SCCL_FREQ_W           3
`define SCCL_FREQ_25          3'h0
`define SCCL_FREQ_125         3'h1
`define SCCL_FREQ_156         3'h2
`define SCCL_FREQ_250         3'h3

// ==========================================================
// Divider settings
`define SCCL_DIV_W            2
`define SCCL_DIV_NORMAL       2'h0
`define SCCL_DIV_LOW_POWER    2'h2
`define SCCL_LOW_POWER_RATIO  2'h3

// ==========================================================
// Timing
`define SCCL_CLK_PERIOD_PS    4000
`define SCCL_TEMP_NORMAL_US   500
`define SCCL_TEMP_LOWPWR_US   1500
`define SCCL_CNT_W            20
`define SCCL_IFG_W            4
`define SCCL_IFG_MIN_NORMAL   4'hc
`define SCCL_IFG_MIN_LOWPWR   4'he
`define SCCL_IFG_MAX_LOWPWR   4'hf
`define SCCL_TS_STEP_W        8
`define SCCL_TS_STEP_NORMAL   8'h04
`define SCCL_TS_STEP_LOWPWR   8'h0c

`endif

// file: sccl_sync_edge.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for a PLL lock level
module sccl_sync_edge (
    input  wire mclk,
    input  wire sys_rst,
    input  wire async_in,
    output wire sync_out
);
    reg meta_q;
    reg sync_q;

    always @(posedge mclk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sccl_regs.vh"

module tb_top;
    // ==========================================================
    // Stimulus, inputs change at the falling edge
    logic       mclk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       sel_s = 1'b0, sec_en = 1'b0, src_sel = 1'b0, halve = 1'b0;
    logic [2:0] pf_s = 3'h0, sf_s = 3'h0;
    logic [1:0] div = 2'h0;
    logic       p_lock = 1'b1, s_lock = 1'b1, dpll = 1'b0, temp_en = 1'b0;
    wire        sec_on, cpu_src, core_src, serdes_src, lp, ce, ts_ce, temp_rf;
    wire        p_ok, s_ok, dpll_ok, sw;
    wire  [7:0] ts_step;
    wire  [3:0] ifg_min, ifg_max;
    int         n_mismatch = 0, num_checks = 0, cycles = 0, n_ce, n_tr, n_ts;

    // Short refresh counts keep the run small
    sccl_core #(.TEMP_NORMAL_CYC(20'd10), .TEMP_LOWPWR_CYC(20'd30)) dut (.mclk(mclk),
        .sys_rst(sys_rst), .secondary_pll_select_strap(sel_s), .primary_ref_freq_strap(pf_s),
        .secondary_ref_freq_strap(sf_s), .secondary_pll_enable(sec_en),
        .core_clock_source_select(src_sel), .core_clock_halve(halve), .core_clock_divider(div),
        .primary_pll_lock(p_lock), .secondary_pll_lock(s_lock), .dpll_sync_active(dpll),
        .temp_sensor_enable(temp_en), .secondary_pll_on_q(sec_on), .cpu_clock_source_q(cpu_src),
        .core_clock_source_q(core_src), .serdes_ref_source_q(serdes_src), .low_power_q(lp),
        .core_clock_enable(ce), .ts_clock_enable_q(ts_ce), .ts_step_q(ts_step),
        .temp_refresh_q(temp_rf), .hdx_ifg_min_q(ifg_min), .hdx_ifg_max_q(ifg_max),
        .primary_ref_ok_q(p_ok), .secondary_ref_ok_q(s_ok), .dpll_sync_allowed_q(dpll_ok),
        .switching_q(sw));

    initial begin
        forever #2 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic count(input int n);
        n_ce = 0;
        n_tr = 0;
        n_ts = 0;
        repeat (n) begin
            @(negedge mclk);
            n_ce += int'(ce);
            n_tr += int'(temp_rf);
            n_ts += int'(ts_ce);
        end
    endtask

    // Straps are moved after release, as the pins are reused then
    task automatic do_reset(input logic s, input logic [2:0] pf, input logic [2:0] sf);
        @(negedge mclk);
        sys_rst = 1'b1;
        sel_s = s;
        pf_s = pf;
        sf_s = sf;
        wait_cyc(20);
        sys_rst = 1'b0;
        wait_cyc(4);
        sel_s = ~s;
        pf_s = 3'h7;
        sf_s = 3'h7;
        wait_cyc(2);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            complete_run;
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        do_reset(1'b0, 3'h0, 3'h0);
        chk("cpu_src", cpu_src, 8'h00);
        chk("core_src", core_src, 8'h00);
        chk("sec_on", sec_on, 8'h00);
        chk("serdes_src", serdes_src, 8'h00);
        chk("p_ok", p_ok, 8'h01);
        chk("s_ok", s_ok, 8'h00);
        chk("ifg", {ifg_min, ifg_max}, 8'hcc);
        chk("ts_step", ts_step, 8'h04);
        chk("dpll_idle", dpll_ok, 8'h00);
        temp_en = 1'b1;
        count(20);
        count(90);
        chk("temp_norm", n_tr[7:0], 8'd9);
        chk("ce_norm", n_ce[7:0], 8'd90);
        chk("ts_ce_norm", n_ts[7:0], 8'd90);
        // Switch to a secondary pll that is off, then unlocked
        s_lock = 1'b0;
        src_sel = 1'b1;
        wait_cyc(6);
        chk("sw_wait", sw, 8'h01);
        chk("core_hold", core_src, 8'h00);
        sec_en = 1'b1;
        wait_cyc(6);
        chk("sec_on_ctl", sec_on, 8'h01);
        chk("core_unlocked", core_src, 8'h00);
        s_lock = 1'b1;
        wait_cyc(8);
        chk("core_sec", core_src, 8'h01);
        chk("sw_done", sw, 8'h00);
        chk("cpu_fixed", cpu_src, 8'h00);
        sec_en = 1'b0;
        wait_cyc(2);
        chk("sec_sticky", sec_on, 8'h01);
        // Halving alone is not low power
        halve = 1'b1;
        wait_cyc(6);
        chk("lp_halve", lp, 8'h00);
        // Slot tables and timer period fields are programmed outside this block
        div = `SCCL_DIV_LOW_POWER;
        dpll = 1'b1;
        wait_cyc(6);
        chk("lp_on", lp, 8'h01);
        chk("ifg_lp", {ifg_min, ifg_max}, 8'hef);
        chk("ts_step_lp", ts_step, 8'h0c);
        chk("dpll_ok", dpll_ok, 8'h01);
        count(60);
        count(90);
        chk("temp_lp", n_tr[7:0], 8'd3);
        chk("ce_lp", n_ce[7:0], 8'd30);
        chk("ts_ce_lp", n_ts[7:0], 8'd30);
        halve = 1'b0;
        div = `SCCL_DIV_NORMAL;
        // Code 4 is a reserved frequency strap and must be flagged on both inputs
        for (int f = 1; f < 5; f++) begin
            do_reset(1'b1, f[2:0], f[2:0]);
            chk("s_ok_f", s_ok, (f < 4) ? 8'h01 : 8'h00);
            chk("p_ok_f", p_ok, (f < 4) ? 8'h01 : 8'h00);
            chk("cpu_sec", cpu_src, 8'h01);
            chk("core_sec_strap", core_src, 8'h01);
            chk("sec_on_strap", sec_on, 8'h01);
        end
        complete_run;
    end
endmodule
`default_nettype wire
